/* File: hdl/burst_sram_pkg.sv */
// ==========================================================
// Shared constants for the flow-through burst memory port
package burst_sram_pkg;

	// ==========================================================
	// Geometry
	localparam int ADDR_W_DEF = 18;   // Word address width
	localparam int LANES_DEF  = 4;    // Byte lanes per word
	localparam int BYTE_W     = 8;    // Data bits per lane
	localparam int LANE_W     = 9;    // Data plus parity bit per lane
	localparam int BURST_W    = 2;    // Burst counter width

	// ==========================================================
	// Burst order strap levels
	localparam logic ORDER_LINEAR      = 1'h0;
	localparam logic ORDER_INTERLEAVED = 1'h1;

	// ==========================================================
	// Counter reset value and increment step
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

	// ==========================================================
	// Sleep timing in clock cycles
	localparam int SLEEP_CYCLES = 2;  // Entry and exit both take this long
	localparam logic [1:0] SLEEP_LAST = 2'(SLEEP_CYCLES - 1);

	// Power state of the port
	typedef enum logic [1:0] {
		st_awake,
		st_entering,
		st_asleep,
		st_leaving
	} power_e;

endpackage

/* File: hdl/burst_counter.sv */
`timescale 1ns/1ps
// ==========================================================
// Two-bit wraparound burst counter with linear or interleaved order
module burst_counter
	import burst_sram_pkg::*;
(
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rstn,
	// Control
	input  wire logic                 i_load,
	input  wire logic                 i_advance,
	input  wire logic                 i_order,
	input  wire logic [BURST_W-1:0]   i_first,
	// Low address bits and access index
	output logic      [BURST_W-1:0]   o_low,
	output logic      [BURST_W-1:0]   o_low_next,
	output logic      [BURST_W-1:0]   o_index
);

	logic [BURST_W-1:0] base_reg;     // First address of the burst
	logic [BURST_W-1:0] base_next;
	logic [BURST_W-1:0] index_reg;    // Access number within burst
	logic [BURST_W-1:0] index_next;

	// ==========================================================
	// Order mapping: xor for interleaved, add for linear
	function automatic logic [BURST_W-1:0] map_low(input logic [BURST_W-1:0] b,
		input logic [BURST_W-1:0] k, input logic ord);
		if (ord == ORDER_INTERLEAVED) begin
			return b ^ k;
		end
		return BURST_W'(b + k);
	endfunction

	// Next counter state
	always_comb begin
		base_next  = base_reg;
		index_next = index_reg;
		if (i_load) begin
			// Low address bits seed the counter
			base_next  = i_first;
			index_next = BURST_RST;
		end else if (i_advance) begin
			// Wraps after four accesses
			index_next = BURST_W'(index_reg + BURST_ONE);
		end
	end

	// Counter registers
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			base_reg  <= BURST_RST;
			index_reg <= BURST_RST;
		end else begin
			base_reg  <= base_next;
			index_reg <= index_next;
		end
	end

	// Outputs
	assign o_low      = map_low(base_reg, index_reg, i_order);
	assign o_low_next = map_low(base_next, index_next, i_order);
	assign o_index    = index_reg;

endmodule

/* File: hdl/lane_memory.sv */
`timescale 1ns/1ps
// ==========================================================
// Word memory with per-lane write enables and a registered read
module lane_memory
	import burst_sram_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF,
	parameter int LANES  = LANES_DEF
)(
	// Clock
	input  wire logic                      i_clk,
	// Access
	input  wire logic [ADDR_W-1:0]         i_addr,
	input  wire logic [LANES-1:0]          i_we,
	input  wire logic [LANES*LANE_W-1:0]   i_wdata,
	// Read data
	output logic      [LANES*LANE_W-1:0]   o_rdata
);

	logic [LANES*LANE_W-1:0] mem [2**ADDR_W];   // Storage, not reset
	logic [LANES*LANE_W-1:0] rdata_reg;         // Read data register

	// ==========================================================
	// One writer per lane, each lane carries its parity bit
	genvar g;
	for (g = 0; g < LANES; g++) begin : g_lane
		always_ff @(posedge i_clk) begin
			if (i_we[g]) begin
				mem[i_addr][g*LANE_W +: LANE_W] <= i_wdata[g*LANE_W +: LANE_W];
			end
		end
	end

	// Read of the location addressed at this edge
	always_ff @(posedge i_clk) begin
		rdata_reg <= mem[i_addr];
	end

	assign o_rdata = rdata_reg;

endmodule

/* File: hdl/burst_sram_port.sv */
`timescale 1ns/1ps
// How it works
// - Capture address on every accepted strobe, selected or not
// - Low two address bits seed burst counter
// - Accepted strobe latches address and counter
// - Both strobes low: processor strobe wins
// - Processor strobe ignored when first select high
// - Selected: first, third low, second high
// - Selects only sampled on new address
// - Advance low increments, high holds address
// - Counter two bits, wraps, four accesses
// - Low byte select writes its byte
// - Byte gate high: byte selects ignored
// - All-bytes write low writes every byte
// - Parity bit follows its byte select
// - Output enable low drives data pins
// - First read after deselect stays tristated
// - Tristate on write, after deselect, deselected
// - Data from location of previous edge
// - Strap low linear, high interleaved
// - Sleep input parks port, keeps data
// - Write when all-bytes or gate plus select
// - Sleep entry and exit take two cycles
module burst_sram_port
	import burst_sram_pkg::*;
#(
	parameter int ADDR_W = burst_sram_pkg::ADDR_W_DEF,
	parameter int LANES  = burst_sram_pkg::LANES_DEF
)(
	// Clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_rstn,
	// Address and strobes
	input  wire logic [ADDR_W-1:0]           i_addr,
	input  wire logic                        i_processor_addr_strobe_n,
	input  wire logic                        i_controller_addr_strobe_n,
	input  wire logic                        i_burst_advance_n,
	// Chip selects
	input  wire logic                        i_chip_select_first_n,
	input  wire logic                        i_chip_select_second,
	input  wire logic                        i_chip_select_third_n,
	// Write enables
	input  wire logic                        i_byte_write_gate_n,
	input  wire logic [LANES-1:0]            i_byte_select_n,
	input  wire logic                        i_all_bytes_write_n,
	// Output enable, burst order strap, sleep
	input  wire logic                        i_oe_n,
	input  wire logic                        i_burst_order,
	input  wire logic                        i_sleep_request,
	// Data pins
	input  wire logic [LANES*BYTE_W-1:0]     i_dq,
	output logic      [LANES*BYTE_W-1:0]     o_dq,
	output logic      [LANES*BYTE_W-1:0]     o_dq_oe,
	// Parity pins
	input  wire logic [LANES-1:0]            i_parity_lines,
	output logic      [LANES-1:0]            o_parity_lines,
	output logic      [LANES-1:0]            o_parity_lines_oe,
	// Status
	output logic                             o_sleeping
);

	import burst_sram_pkg::*;

	// ==========================================================
	// Declarations
	logic [ADDR_W-1:0]         addr_reg;        // Captured address
	logic [ADDR_W-1:0]         addr_next;
	logic                      active_reg;      // Device selected
	logic                      active_next;
	logic                      drive_reg;       // Pins driven
	logic                      drive_next;
	logic                      sleeping_reg;    // Sleep status
	power_e                    power_reg;       // Power state
	logic [1:0]                pcount_reg;      // Sleep step counter
	logic                      awake;           // Accesses allowed
	logic                      cs_ok;           // Select decode
	logic                      proc_taken;      // Processor strobe accepted
	logic                      ctrl_taken;      // Controller strobe accepted
	logic                      load;            // New external address
	logic                      advance;         // Burst step
	logic                      write_req;       // Write inputs say write
	logic                      do_write;        // Write this edge
	logic                      first_after_off; // First access after deselect
	logic [LANES-1:0]          lane_we;         // Lane write enables
	logic [LANES-1:0]          lane_sel;        // Lanes picked by byte gate
	logic [BURST_W-1:0]        low_cur;         // Counter low bits
	logic [BURST_W-1:0]        low_next;
	logic [BURST_W-1:0]        burst_index;     // Access number
	logic [LANES*LANE_W-1:0]   wdata;           // Packed write lanes
	logic [LANES*LANE_W-1:0]   rdata;           // Packed read lanes
	logic [ADDR_W-1:0]         mem_addr;        // Core address this edge

	// ==========================================================
	// Strobe and select decode
	always_comb begin
		awake      = (power_reg == st_awake);
		cs_ok      = !i_chip_select_first_n && i_chip_select_second
			&& !i_chip_select_third_n;
		// Processor strobe needs first select low
		proc_taken = awake && !i_processor_addr_strobe_n
			&& !i_chip_select_first_n;
		// Controller strobe loses to an accepted processor strobe
		ctrl_taken = awake && !i_controller_addr_strobe_n && !proc_taken;
		load       = proc_taken || ctrl_taken;
		advance    = awake && !load && active_reg && !i_burst_advance_n;
	end

	// Write decode
	always_comb begin
		lane_sel  = i_byte_write_gate_n ? '0 : ~i_byte_select_n;
		write_req = !i_all_bytes_write_n || (|lane_sel);
		// Selects only matter on a new address
		active_next = awake ? (load ? cs_ok : active_reg) : 1'b0;
		// Write inputs are ignored on a processor-strobe start
		do_write    = active_next && write_req && !proc_taken;
		if (!do_write) begin
			lane_we = '0;
		end else if (!i_all_bytes_write_n) begin
			lane_we = '1;
		end else begin
			lane_we = lane_sel;
		end
		first_after_off = load && cs_ok && !active_reg;
		// Drive only a selected read, never its first cycle after deselect
		drive_next = active_next && !do_write && !first_after_off && !i_oe_n;
	end

	// ==========================================================
	// Address path
	always_comb begin
		if (load) begin
			addr_next = i_addr;
		end else begin
			addr_next = addr_reg;
		end
		mem_addr = {addr_next[ADDR_W-1:BURST_W], low_next};
	end

	// Captured address register
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_reg <= '0;
		end else begin
			addr_reg <= addr_next;
		end
	end

	// Selection state
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= active_next;
		end
	end

	// Burst counter
	burst_counter u_counter (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_load     (load),
		.i_advance  (advance),
		.i_order    (i_burst_order),
		.i_first    (i_addr[BURST_W-1:0]),
		.o_low      (low_cur),
		.o_low_next (low_next),
		.o_index    (burst_index)
	);

	// ==========================================================
	// Lane packing: each lane holds its byte and parity bit
	genvar g;
	for (g = 0; g < LANES; g++) begin : g_pack
		assign wdata[g*LANE_W +: LANE_W] = {i_parity_lines[g], i_dq[g*BYTE_W +: BYTE_W]};
		assign o_dq[g*BYTE_W +: BYTE_W]  = rdata[g*LANE_W +: BYTE_W];
		assign o_parity_lines[g]         = rdata[g*LANE_W + BYTE_W];
	end

	// Memory core, read data registered at the addressing edge
	lane_memory #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES)
	) u_mem (
		.i_clk   (i_clk),
		.i_addr  (mem_addr),
		.i_we    (lane_we),
		.i_wdata (wdata),
		.o_rdata (rdata)
	);

	// ==========================================================
	// Output drive enable
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			drive_reg <= 1'b0;
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign o_dq_oe           = {(LANES*BYTE_W){drive_reg}};
	assign o_parity_lines_oe = {LANES{drive_reg}};

	// ==========================================================
	// Sleep sequencing
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			power_reg  <= st_awake;
			pcount_reg <= 2'h0;
		end else begin
			unique case (power_reg)
				st_awake: begin
					// Pending access is dropped
					if (i_sleep_request) begin
						power_reg  <= st_entering;
						pcount_reg <= 2'h1;
					end
				end
				st_entering: begin
					if (pcount_reg == SLEEP_LAST) begin
						power_reg <= st_asleep;
					end else begin
						pcount_reg <= 2'(pcount_reg + 2'h1);
					end
				end
				st_asleep: begin
					// Memory contents untouched while parked
					if (!i_sleep_request) begin
						power_reg  <= st_leaving;
						pcount_reg <= 2'h1;
					end
				end
				st_leaving: begin
					if (pcount_reg == SLEEP_LAST) begin
						power_reg <= st_awake;
					end else begin
						pcount_reg <= 2'(pcount_reg + 2'h1);
					end
				end
			endcase
		end
	end

	// Sleep status flag
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sleeping_reg <= 1'b0;
		end else begin
			sleeping_reg <= (power_reg == st_entering && pcount_reg == SLEEP_LAST)
				|| power_reg == st_asleep
				|| (power_reg == st_leaving && pcount_reg != SLEEP_LAST);
		end
	end

	assign o_sleeping = sleeping_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	a_addr_capture: assert property (load |=> addr_reg == $past(i_addr))
		else $error("Address not captured on accepted strobe");
	a_low_seed: assert property (load |=> low_cur == $past(i_addr[BURST_W-1:0]))
		else $error("Counter not seeded from low address bits");
	a_proc_wins: assert property (awake && !i_processor_addr_strobe_n && !i_chip_select_first_n
		&& !i_controller_addr_strobe_n |-> lane_we == '0)
		else $error("Controller strobe acted when processor strobe won");
	a_ce1_gate: assert property (i_chip_select_first_n && i_controller_addr_strobe_n |-> !load)
		else $error("Processor strobe taken with first select high");
	a_select_decode: assert property (load |=> active_reg == $past(cs_ok))
		else $error("Select decode wrong");
	a_select_hold: assert property (awake && !load |=> active_reg == $past(active_reg))
		else $error("Selects sampled outside address load");
	a_burst_step: assert property (advance |=> burst_index == 2'($past(burst_index) + 2'h1))
		else $error("Burst counter did not advance");
	a_burst_hold: assert property (awake && !load && i_burst_advance_n |=> $stable(low_cur))
		else $error("Burst address moved while suspended");
	// Low address follows captured first pair and access index
	a_order_map: assert property (low_cur == ((i_burst_order == ORDER_INTERLEAVED)
		? (addr_reg[BURST_W-1:0] ^ burst_index)
		: BURST_W'(addr_reg[BURST_W-1:0] + burst_index)))
		else $error("Burst order mapping wrong");
	a_global_write: assert property (do_write && !i_all_bytes_write_n |-> &lane_we)
		else $error("All-bytes write missed a lane");
	a_gate_off: assert property (i_byte_write_gate_n && i_all_bytes_write_n |-> lane_we == '0)
		else $error("Byte select wrote without gate");
	a_tristate_write: assert property (do_write |=> !drive_reg)
		else $error("Pins driven during write");
	a_first_masked: assert property (first_after_off |=> !drive_reg)
		else $error("Pins driven on first cycle after deselect");
	a_sleep_entry: assert property (power_reg == st_awake && i_sleep_request
		|=> ##1 power_reg == st_asleep && o_sleeping)
		else $error("Sleep entry did not take two cycles");

	c_proc_read: cover property (proc_taken && cs_ok ##1 drive_reg);
	c_ctrl_write: cover property (ctrl_taken && do_write);
	c_full_burst: cover property (advance [*3]);
	c_sleep_cycle: cover property (power_reg == st_asleep ##[1:20] power_reg == st_awake);

endmodule

/* File: bench/bus_master_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Bus master model: processor and cache controller side
module bus_master_model
	import burst_sram_pkg::*;
(
	// Clock
	input  wire logic                        i_clk,
	// Address and burst control
	output logic [ADDR_W_DEF-1:0]            o_addr,
	output logic                             o_processor_addr_strobe_n,
	output logic                             o_controller_addr_strobe_n,
	output logic                             o_burst_advance_n,
	// Selects as first_n, second, third_n
	output logic [2:0]                       o_chip_select,
	// Write enables
	output logic                             o_byte_write_gate_n,
	output logic [LANES_DEF-1:0]             o_byte_select_n,
	output logic                             o_all_bytes_write_n,
	// Output enable, strap, sleep
	output logic                             o_oe_n,
	output logic                             o_burst_order,
	output logic                             o_sleep_request,
	// Write data, parity bits on top
	output logic [LANES_DEF*LANE_W-1:0]      o_wdata
);
	// Quiet, deselected bus at time zero
	initial begin
		o_addr                     = '0;
		o_processor_addr_strobe_n  = 1'b1;
		o_controller_addr_strobe_n = 1'b1;
		o_burst_advance_n          = 1'b1;
		o_chip_select              = 3'h5;
		{o_byte_write_gate_n, o_all_bytes_write_n, o_byte_select_n} = 6'h3f;
		o_oe_n                     = 1'b1;
		o_burst_order              = ORDER_INTERLEAVED;
		o_sleep_request            = 1'b0;
		o_wdata                    = '0;
	end

	// ==========================================================
	// Strap changes only while the port is held in reset
	task automatic strap(input logic ord);
		@(negedge i_clk);
		o_burst_order = ord;
	endtask

	// One bus cycle, launched after a falling edge, held over the rising edge
	task automatic cycle(input logic [1:0] strb_n, input logic adv_n, input logic [2:0] sel,
			input logic [ADDR_W_DEF-1:0] addr, input logic [5:0] wr_n, input logic [35:0] data);
		@(negedge i_clk);
		{o_processor_addr_strobe_n, o_controller_addr_strobe_n} = strb_n;
		o_burst_advance_n = adv_n;
		o_chip_select     = sel;
		o_addr            = addr;
		{o_byte_write_gate_n, o_all_bytes_write_n, o_byte_select_n} = wr_n;
		o_sleep_request   = 1'b0;
		// Write cycle: output enable released before data goes out
		if (!wr_n[4] || (!wr_n[5] && wr_n[3:0] != 4'hf)) begin
			o_oe_n  = 1'b1;
			o_wdata = data;
		end else begin
			o_oe_n  = 1'b0;
			// Released lines toggle so no stale value passes for data
			o_wdata = ~o_wdata;
		end
	endtask

	// Read cycle with every write enable held off
	task automatic rd(input logic [1:0] strb_n, input logic adv_n, input logic [2:0] sel,
			input logic [ADDR_W_DEF-1:0] addr);
		cycle(strb_n, adv_n, sel, addr, 6'h3f, '0);
	endtask

	// Sleep level with strobes idle; caller deselects first
	task automatic nap(input logic lvl);
		@(negedge i_clk);
		{o_processor_addr_strobe_n, o_controller_addr_strobe_n} = 2'h3;
		o_sleep_request = lvl;
	endtask
endmodule

/* File: bench/flow_through_burst_sram_port_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the flow-through burst port
module flow_through_burst_sram_port_test;
	import burst_sram_pkg::*;

	localparam logic [2:0]  SEL_OK = 3'h2;        // First low, second high, third low
	localparam logic [2:0]  SEL_NO = 3'h6;        // First select high
	localparam logic [17:0] BASE   = 18'h0_5a30;  // High address bits of every access

	// ==========================================================
	// Nets, expectations, counters
	logic                  clk;
	logic                  rstn;
	logic [17:0]           addr;
	logic                  processor_addr_strobe_n;
	logic                  controller_addr_strobe_n;
	logic                  burst_advance_n;
	logic [2:0]            chip_select;
	logic                  byte_write_gate_n;
	logic [3:0]            byte_select_n;
	logic                  all_bytes_write_n;
	logic                  oe_n;
	logic                  burst_order;
	logic                  sleep_request;
	logic [35:0]           wdata;
	logic [31:0]           rd_dq;
	logic [31:0]           dq_oe;
	logic [3:0]            rd_par;
	logic [3:0]            par_oe;
	logic                  sleeping;
	logic [35:0]           exp_mem [4];    // Expected word per low address pair
	int                    fail_count;
	int                    compares;

	bus_master_model u_master (
		.i_clk(clk), .o_addr(addr), .o_processor_addr_strobe_n(processor_addr_strobe_n),
		.o_controller_addr_strobe_n(controller_addr_strobe_n), .o_burst_advance_n(burst_advance_n),
		.o_chip_select(chip_select), .o_byte_write_gate_n(byte_write_gate_n),
		.o_byte_select_n(byte_select_n), .o_all_bytes_write_n(all_bytes_write_n), .o_oe_n(oe_n),
		.o_burst_order(burst_order), .o_sleep_request(sleep_request), .o_wdata(wdata)
	);

	burst_sram_port u_dut (
		.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_processor_addr_strobe_n(processor_addr_strobe_n),
		.i_controller_addr_strobe_n(controller_addr_strobe_n), .i_burst_advance_n(burst_advance_n),
		.i_chip_select_first_n(chip_select[2]), .i_chip_select_second(chip_select[1]),
		.i_chip_select_third_n(chip_select[0]), .i_byte_write_gate_n(byte_write_gate_n),
		.i_byte_select_n(byte_select_n), .i_all_bytes_write_n(all_bytes_write_n), .i_oe_n(oe_n),
		.i_burst_order(burst_order), .i_sleep_request(sleep_request), .i_dq(wdata[31:0]),
		.o_dq(rd_dq), .o_dq_oe(dq_oe), .i_parity_lines(wdata[35:32]), .o_parity_lines(rd_par),
		.o_parity_lines_oe(par_oe), .o_sleeping(sleeping)
	);

	// Clock at 125 MHz
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================================
	// Compare helpers and reference functions
	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Low address pair for access k of a burst
	function automatic logic [1:0] seq(input logic [1:0] first, input logic [1:0] k, input logic ord);
		return (ord == ORDER_INTERLEAVED) ? (first ^ k) : (first + k);
	endfunction

	// Lanes with a low select take the new byte and parity bit
	function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] sel_n);
		logic [35:0] r;
		r = old;
		for (int g = 0; g < 4; g++) begin
			if (!sel_n[g]) begin
				r[g*8+:8] = nw[g*8+:8];
				r[32+g]   = nw[32+g];
			end
		end
		return r;
	endfunction

	// Reset held over the strap's falling edge plus six more cycles
	task automatic do_reset(input logic ord);
		rstn = 1'b0;
		u_master.strap(ord);
		repeat (6) @(negedge clk);
		rstn = 1'b1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic burst_test(input logic ord);
		logic [35:0] d;
		do_reset(ord);
		// Controller write burst from pair 2, all-bytes strobe, wrapping
		for (int k = 0; k < 4; k++) begin
			d = {4'(k + 1), 24'h5a_c3e0, 7'(k), ord};
			exp_mem[seq(2'h2, 2'(k), ord)] = d;
			u_master.cycle(k == 0 ? 2'h2 : 2'h3, k == 0, SEL_OK, k == 0 ? BASE | 18'h0_0002 : 18'h0,
				k == 0 ? 6'h25 : 6'h2f, d);
			if (k > 0) chk_word({par_oe, dq_oe}, '0);
		end
		// Processor read burst from pair 1; selects toggle mid-burst
		u_master.rd(2'h1, 1'b1, SEL_OK, BASE | 18'h0_0001);
		chk_word({par_oe, dq_oe}, '0);
		for (int k = 0; k < 4; k++) begin
			u_master.rd(2'h3, k == 3, SEL_NO, 18'h0);
			chk_word({rd_par, rd_dq}, exp_mem[seq(2'h1, 2'(k), ord)]);
			chk_word({par_oe, dq_oe}, '1);
		end
		u_master.rd(2'h3, 1'b1, SEL_NO, 18'h0);
		chk_word({rd_par, rd_dq}, exp_mem[seq(2'h1, 2'h3, ord)]);
		$display("test burst order %0d done", ord);
	endtask

	task automatic bytes_test();
		logic [35:0] x;
		x = 36'h9_1234_5678;
		// Whole word, then lanes 0 and 2 only, then selects without gate
		u_master.cycle(2'h2, 1'b1, SEL_OK, BASE, 6'h20, x);
		u_master.cycle(2'h3, 1'b1, SEL_NO, 18'h0, 6'h1a, ~x);
		exp_mem[0] = merge(x, ~x, 4'ha);
		u_master.cycle(2'h3, 1'b1, SEL_NO, 18'h0, 6'h30, 36'h0);
		// Both strobes low with writes asserted: processor start, no write
		u_master.cycle(2'h0, 1'b1, SEL_OK, BASE | 18'h0_0003, 6'h20, x);
		chk_word({rd_par, rd_dq}, exp_mem[0]);
		// Processor strobe with first select high is ignored
		u_master.rd(2'h1, 1'b1, SEL_NO, BASE);
		chk_word({rd_par, rd_dq}, exp_mem[3]);
		u_master.rd(2'h3, 1'b1, SEL_NO, 18'h0);
		chk_word({rd_par, rd_dq}, exp_mem[3]);
		u_master.rd(2'h2, 1'b1, SEL_OK, BASE);
		u_master.rd(2'h3, 1'b1, SEL_NO, 18'h0);
		chk_word({rd_par, rd_dq}, exp_mem[0]);
		$display("test byte writes done");
	endtask

	task automatic deselect_test();
		logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
		foreach (bad[i]) begin
			u_master.rd(2'h2, 1'b1, bad[i], BASE);
			u_master.rd(2'h1, 1'b1, SEL_OK, BASE | 18'h0_0003);
			chk_word({par_oe, dq_oe}, '0);
			u_master.rd(2'h3, 1'b1, SEL_NO, 18'h0);
			chk_word({par_oe, dq_oe}, '0);
			chk_word({rd_par, rd_dq}, exp_mem[3]);
			u_master.rd(2'h3, 1'b1, SEL_NO, 18'h0);
			chk_word({par_oe, dq_oe}, '1);
		end
		$display("test deselect done");
	endtask

	task automatic sleep_test();
		u_master.rd(2'h2, 1'b1, SEL_NO, BASE);
		u_master.nap(1'b1);
		u_master.nap(1'b1);
		chk_bit(sleeping, 1'b0);
		u_master.nap(1'b1);
		chk_bit(sleeping, 1'b1);
		u_master.nap(1'b0);
		u_master.nap(1'b0);
		chk_bit(sleeping, 1'b1);
		repeat (2) u_master.nap(1'b0);
		chk_bit(sleeping, 1'b0);
		u_master.rd(2'h1, 1'b1, SEL_OK, BASE | 18'h0_0003);
		u_master.rd(2'h3, 1'b1, SEL_NO, 18'h0);
		chk_word({rd_par, rd_dq}, exp_mem[3]);
		$display("test sleep done");
	endtask

	// ==========================================================
	// Verdict and run control
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		fail_count = 0;
		compares   = 0;
		burst_test(ORDER_LINEAR);
		burst_test(ORDER_INTERLEAVED);
		bytes_test();
		deselect_test();
		sleep_test();
		finish_test();
	end

	// Watchdog well beyond the roughly 65 cycles the scenarios need
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
